// [rtl/cfds_pkg.sv]
package cfds_pkg;
  localparam int CFDS_W = 16;
  localparam int CFDS_NREG = 8;
  localparam logic [2:0] CFDS_SP_IDX = 3'h6;
  localparam logic [2:0] CFDS_PC_IDX = 3'h7;
  localparam logic [15:0] CFDS_PC_STEP = 16'h0002;
  localparam logic [15:0] CFDS_TRACE_VEC = 16'h000c;
  localparam logic [15:0] CFDS_STACK_LIMIT = 16'h0100;
  localparam logic [15:0] CFDS_PC_RESET = 16'h0000;
  localparam logic [15:0] CFDS_PSW_RESET = 16'h0000;
  localparam logic [15:0] CFDS_PSW_MASK = 16'h00ff;
  localparam int CFDS_PRI_HI = 7;
  localparam int CFDS_PRI_LO = 5;
  localparam int CFDS_TBIT = 4;
  localparam logic [2:0] CFDS_ADDR_PSW = 3'h0;
  localparam logic [2:0] CFDS_ADDR_ERR = 3'h1;
  localparam logic [2:0] CFDS_ADDR_ACT = 3'h2;
  localparam logic [2:0] CFDS_ADDR_PC = 3'h3;
  localparam logic [2:0] CFDS_ADDR_SP = 3'h4;
  localparam logic [2:0] CFDS_ADDR_INSN = 3'h5;
  localparam logic [2:0] CFDS_ADDR_CC = 3'h6;

  typedef enum logic [1:0] {
    CFDS_RUN = 2'h0,
    CFDS_WAIT = 2'h1,
    CFDS_OFF = 2'h2
  } cfds_act_t;

  typedef enum logic [1:0] {
    CFDS_S_FETCH,
    CFDS_S_EXEC,
    CFDS_S_TRAP
  } cfds_state_t;

  typedef struct packed {
    logic [3:0] bin_op;
    logic [5:0] src_field;
    logic [2:0] src_mode;
    logic src_defer_bit;
    logic [2:0] src_reg;
    logic [5:0] dst_field;
    logic [2:0] dst_mode;
    logic dst_defer_bit;
    logic [2:0] dst_reg;
    logic [9:0] un_op;
    logic [7:0] br_op;
    logic [15:0] br_offset;
    logic [6:0] ext_op;
    logic [2:0] ext_reg_index;
    logic [7:0] flt_op;
    logic [1:0] float_acc_select;
  } cfds_dec_t;

  typedef struct packed {
    logic boundary;
    logic stack_ovf;
    logic timeout;
    logic illegal;
    logic pwr_fail;
    logic pwr_up;
  } cfds_err_t;
endpackage : cfds_pkg

// [rtl/cfds_core.sv]
`timescale 1ns/1ps
// Function
// - Run, no interrupt: fetch, PC plus 2, execute
// - Trace bit: trap via vector 14 octal
// - Odd word address: boundary error, garbage data
// - Byte access: even low, odd high half
// - Eight 16-bit general registers
// - R6 stack pointer, R7 program counter
// - Status bits 7:5 priority, 15:8 unused
// - Status bit 4 trace enable
// - Status bits 3:0 N Z V C
// - Stack access below 400 octal: overflow
// - Nonexistent access sets time-out flag
// - Illegal class instruction sets flag
// - Activity: 0 run, 1 wait, 2 off
// - Power-fail and power-up flags from outside
// - Binary opcode 15:12, source 11:6
// - Source: mode 5:3, defer 3, reg 2:0
// - Destination 5:0: mode, defer, reg
// - Unary opcode bits 15:6
// - Branch/trap opcode 15:8, offset sign-extended
// - Extended: op 15:9, reg 8:6, src 5:0
// - Float: op 15:8, acc 7:6, src 5:0
module cfds_core
  import cfds_pkg::*;
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Software register port
  input wire logic [2:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  // Program memory
  output logic mem_req_out,
  output logic [15:0] mem_addr_out,
  output logic mem_byte_out,
  input wire logic mem_ack_in,
  input wire logic mem_nxm_in,
  input wire logic [15:0] mem_rdata_in,
  output logic [15:0] mem_word_out,
  output logic [7:0] mem_bytev_out,
  // Execution side
  input wire logic irq_pending_in,
  input wire logic exec_done_in,
  input wire logic exec_illegal_in,
  input wire logic exec_sp_access_in,
  input wire logic exec_cc_we_in,
  input wire logic [3:0] exec_cc_in,
  input wire logic exec_reg_we_in,
  input wire logic [2:0] exec_reg_sel_in,
  input wire logic [15:0] exec_reg_data_in,
  input wire logic [1:0] act_set_in,
  input wire logic act_set_we_in,
  input wire logic pwr_low_in,
  input wire logic pwr_on_in,
  output cfds_dec_t dec_out,
  output logic exec_start_out,
  output logic trap_out,
  output logic [15:0] trap_vec_out,
  output cfds_err_t err_out,
  output logic [1:0] err_code_out,
  output logic err_any_out,
  output logic [1:0] activity_out,
  output logic [15:0] sp_out
);
  logic [15:0] gpr [CFDS_NREG];
  logic [15:0] status_word;
  logic [15:0] insn;
  cfds_state_t state;
  cfds_act_t activity;
  cfds_err_t err;
  logic [15:0] rdata;

  function automatic logic [15:0] cfds_sext8(input logic [7:0] v);
    cfds_sext8 = {{8{v[7]}}, v};
  endfunction : cfds_sext8

  wire logic [15:0] pc = gpr[CFDS_PC_IDX];
  wire logic [15:0] sp = gpr[CFDS_SP_IDX];
  wire logic is_run = (activity == CFDS_RUN);
  wire logic go_fetch = is_run && !irq_pending_in;
  wire logic fetch_hit = (state == CFDS_S_FETCH) && go_fetch && mem_ack_in;
  wire logic odd_word = mem_req_out && !mem_byte_out && mem_addr_out[0];
  wire logic trace_on = status_word[CFDS_TBIT];
  wire logic ex_end = (state == CFDS_S_EXEC) && exec_done_in;
  wire logic stk_hit = ex_end && exec_sp_access_in && (sp < CFDS_STACK_LIMIT);
  wire logic wr_psw = reg_wr_in && (reg_addr_in == CFDS_ADDR_PSW);
  wire logic wr_err = reg_wr_in && (reg_addr_in == CFDS_ADDR_ERR);

  // Memory view, phys word from bus
  assign mem_req_out = (state == CFDS_S_FETCH) && go_fetch;
  assign mem_addr_out = pc;
  assign mem_byte_out = 1'b0;
  assign mem_word_out = mem_rdata_in;
  assign mem_bytev_out = pc[0] ? mem_rdata_in[15:8] : mem_rdata_in[7:0];

  // Field split
  assign dec_out.bin_op = insn[15:12];
  assign dec_out.src_field = insn[11:6];
  assign dec_out.src_mode = insn[11:9];
  assign dec_out.src_defer_bit = insn[9];
  assign dec_out.src_reg = insn[8:6];
  assign dec_out.dst_field = insn[5:0];
  assign dec_out.dst_mode = insn[5:3];
  assign dec_out.dst_defer_bit = insn[3];
  assign dec_out.dst_reg = insn[2:0];
  assign dec_out.un_op = insn[15:6];
  assign dec_out.br_op = insn[15:8];
  assign dec_out.br_offset = cfds_sext8(insn[7:0]);
  assign dec_out.ext_op = insn[15:9];
  assign dec_out.ext_reg_index = insn[8:6];
  assign dec_out.flt_op = insn[15:8];
  assign dec_out.float_acc_select = insn[7:6];

  assign exec_start_out = (state == CFDS_S_EXEC);
  assign trap_out = (state == CFDS_S_TRAP);
  assign trap_vec_out = CFDS_TRACE_VEC;
  assign err_out = err;
  assign err_any_out = err.boundary | err.stack_ovf | err.timeout | err.illegal;
  assign err_code_out = err.boundary ? 2'h0 :
                        err.stack_ovf ? 2'h1 :
                        err.timeout ? 2'h2 : 2'h3;
  assign activity_out = activity;
  assign sp_out = sp;
  assign reg_rdata_out = rdata;

  // Sequencer
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= CFDS_S_FETCH;
      insn <= 16'h0000;
    end else begin
      unique case (state)
        CFDS_S_FETCH: begin
          if (fetch_hit && !odd_word && !mem_nxm_in) begin
            insn <= mem_rdata_in;
            state <= CFDS_S_EXEC;
          end
        end
        CFDS_S_EXEC: begin
          if (exec_done_in) begin
            state <= trace_on ? CFDS_S_TRAP : CFDS_S_FETCH;
          end
        end
        CFDS_S_TRAP: begin
          state <= CFDS_S_FETCH;
        end
      endcase
    end
  end

  // Registers: PC step, trap vector, execution writes
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int k = 0; k < CFDS_NREG; k++) begin
        gpr[k] <= CFDS_PC_RESET;
      end
    end else begin
      if (fetch_hit && !odd_word && !mem_nxm_in) begin
        gpr[CFDS_PC_IDX] <= pc + CFDS_PC_STEP;
      end else if (trap_out) begin
        gpr[CFDS_PC_IDX] <= CFDS_TRACE_VEC;
      end else if (exec_reg_we_in && exec_start_out) begin
        gpr[exec_reg_sel_in] <= exec_reg_data_in;
      end
    end
  end

  // Status word
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      status_word <= CFDS_PSW_RESET;
    end else begin
      if (trap_out) begin
        status_word[CFDS_TBIT] <= 1'b0;
      end else if (wr_psw) begin
        status_word <= reg_wdata_in & CFDS_PSW_MASK;
      end else if (ex_end && exec_cc_we_in) begin
        status_word[3:0] <= exec_cc_in;
      end
    end
  end

  // Activity
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      activity <= CFDS_RUN;
    end else if (act_set_we_in && act_set_in != 2'h3) begin
      activity <= cfds_act_t'(act_set_in);
    end
  end

  // Sticky error flags, set wins over clear
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      err <= '0;
    end else begin
      err.boundary <= odd_word | (err.boundary & ~(wr_err & reg_wdata_in[5]));
      err.stack_ovf <= stk_hit | (err.stack_ovf & ~(wr_err & reg_wdata_in[4]));
      err.timeout <= (mem_req_out & mem_nxm_in)
                     | (err.timeout & ~(wr_err & reg_wdata_in[3]));
      err.illegal <= (ex_end & exec_illegal_in)
                     | (err.illegal & ~(wr_err & reg_wdata_in[2]));
      err.pwr_fail <= pwr_low_in | (err.pwr_fail & ~(wr_err & reg_wdata_in[1]));
      err.pwr_up <= pwr_on_in | (err.pwr_up & ~(wr_err & reg_wdata_in[0]));
    end
  end

  // Read port
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata <= 16'h0000;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        CFDS_ADDR_PSW: rdata <= status_word;
        CFDS_ADDR_ERR: rdata <= {10'h000, err};
        CFDS_ADDR_ACT: rdata <= {14'h0000, activity};
        CFDS_ADDR_PC: rdata <= pc;
        CFDS_ADDR_SP: rdata <= sp;
        CFDS_ADDR_INSN: rdata <= insn;
        CFDS_ADDR_CC: rdata <= {12'h000, status_word[3:0]};
        default: rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

  property p_pc_step;
    @(posedge clock_in) disable iff (sys_rst_in)
      (fetch_hit && !odd_word && !mem_nxm_in) |=> (pc == $past(pc) + CFDS_PC_STEP);
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("PC did not step by 2");

  sequence s_trace_end;
    ex_end && trace_on;
  endsequence
  property p_trace;
    @(posedge clock_in) disable iff (sys_rst_in)
      s_trace_end |=> trap_out ##1 (pc == CFDS_TRACE_VEC && !trace_on);
  endproperty
  a_trace: assert property (p_trace) else $error("Trace trap missing");

  property p_bound;
    @(posedge clock_in) disable iff (sys_rst_in) odd_word |=> err.boundary;
  endproperty
  a_bound: assert property (p_bound) else $error("Boundary flag not set");

  property p_stack;
    @(posedge clock_in) disable iff (sys_rst_in) stk_hit |=> err.stack_ovf;
  endproperty
  a_stack: assert property (p_stack) else $error("Stack flag not set");

  property p_tmo;
    @(posedge clock_in) disable iff (sys_rst_in) (mem_req_out && mem_nxm_in) |=> err.timeout;
  endproperty
  a_tmo: assert property (p_tmo) else $error("Timeout flag not set");

  property p_ill;
    @(posedge clock_in) disable iff (sys_rst_in) (ex_end && exec_illegal_in) |=> err.illegal;
  endproperty
  a_ill: assert property (p_ill) else $error("Illegal flag not set");

  property p_nofetch;
    @(posedge clock_in) disable iff (sys_rst_in) (!is_run || irq_pending_in) |-> !mem_req_out;
  endproperty
  a_nofetch: assert property (p_nofetch) else $error("Fetch while not runnable");

  property p_pwr;
    @(posedge clock_in) disable iff (sys_rst_in) pwr_low_in |=> err.pwr_fail;
  endproperty
  a_pwr: assert property (p_pwr) else $error("Power fail flag not set");

  property p_hi;
    @(posedge clock_in) disable iff (sys_rst_in) status_word[15:8] == 8'h00;
  endproperty
  a_hi: assert property (p_hi) else $error("Unused status bits set");

  property p_off;
    @(posedge clock_in) disable iff (sys_rst_in)
      dec_out.br_offset[15:8] == {8{insn[7]}};
  endproperty
  a_off: assert property (p_off) else $error("Offset not sign extended");

  sequence s_fetch_take;
    fetch_hit && !odd_word && !mem_nxm_in;
  endsequence
  property p_fetch_load;
    @(posedge clock_in) disable iff (sys_rst_in)
      s_fetch_take |=> (insn == $past(mem_rdata_in)) && exec_start_out;
  endproperty
  a_fetch_load: assert property (p_fetch_load) else $error("Word not loaded");

  property p_trap_pulse;
    @(posedge clock_in) disable iff (sys_rst_in) trap_out |=> !trap_out;
  endproperty
  a_trap_pulse: assert property (p_trap_pulse) else $error("Trap too long");

  property p_odd_hold;
    @(posedge clock_in) disable iff (sys_rst_in) odd_word |=> (pc == $past(pc));
  endproperty
  a_odd_hold: assert property (p_odd_hold) else $error("Odd fetch taken");

  property p_nxm_hold;
    @(posedge clock_in) disable iff (sys_rst_in)
      (mem_req_out && mem_nxm_in) |=> !exec_start_out;
  endproperty
  a_nxm_hold: assert property (p_nxm_hold) else $error("Missing word taken");

  property p_cc_load;
    @(posedge clock_in) disable iff (sys_rst_in)
      (ex_end && exec_cc_we_in && !wr_psw) |=> (status_word[3:0] == $past(exec_cc_in));
  endproperty
  a_cc_load: assert property (p_cc_load) else $error("Flags not loaded");

  property p_psw_write;
    @(posedge clock_in) disable iff (sys_rst_in)
      (wr_psw && !trap_out) |=> (status_word == ($past(reg_wdata_in) & CFDS_PSW_MASK));
  endproperty
  a_psw_write: assert property (p_psw_write) else $error("Status write lost");

  property p_gpr_write;
    @(posedge clock_in) disable iff (sys_rst_in)
      (exec_reg_we_in && exec_start_out)
      |=> (gpr[$past(exec_reg_sel_in)] == $past(exec_reg_data_in));
  endproperty
  a_gpr_write: assert property (p_gpr_write) else $error("Register write lost");

  property p_bytev_even;
    @(posedge clock_in) disable iff (sys_rst_in)
      !pc[0] |-> (mem_bytev_out == mem_rdata_in[7:0]);
  endproperty
  a_bytev_even: assert property (p_bytev_even) else $error("Even byte wrong");

  property p_bytev_odd;
    @(posedge clock_in) disable iff (sys_rst_in)
      pc[0] |-> (mem_bytev_out == mem_rdata_in[15:8]);
  endproperty
  a_bytev_odd: assert property (p_bytev_odd) else $error("Odd byte wrong");

  property p_src_split;
    @(posedge clock_in) disable iff (sys_rst_in)
      (dec_out.src_mode == dec_out.src_field[5:3])
      && (dec_out.src_defer_bit == dec_out.src_field[3])
      && (dec_out.src_reg == dec_out.src_field[2:0]);
  endproperty
  a_src_split: assert property (p_src_split) else $error("Source split wrong");

  property p_dst_split;
    @(posedge clock_in) disable iff (sys_rst_in)
      (dec_out.dst_mode == dec_out.dst_field[5:3])
      && (dec_out.dst_defer_bit == dec_out.dst_field[3])
      && (dec_out.dst_reg == dec_out.dst_field[2:0]);
  endproperty
  a_dst_split: assert property (p_dst_split) else $error("Dest split wrong");

  property p_unop;
    @(posedge clock_in) disable iff (sys_rst_in)
      (dec_out.un_op[9:6] == dec_out.bin_op) && (dec_out.un_op[5:0] == dec_out.src_field);
  endproperty
  a_unop: assert property (p_unop) else $error("Unary op wrong");

  property p_ext;
    @(posedge clock_in) disable iff (sys_rst_in)
      (dec_out.ext_reg_index == dec_out.src_reg) && (dec_out.ext_op[6:3] == dec_out.bin_op);
  endproperty
  a_ext: assert property (p_ext) else $error("Extended op wrong");

  property p_flt;
    @(posedge clock_in) disable iff (sys_rst_in)
      (dec_out.flt_op == dec_out.br_op) && (dec_out.float_acc_select == dec_out.src_field[1:0]);
  endproperty
  a_flt: assert property (p_flt) else $error("Float op wrong");

  property p_act_enc;
    @(posedge clock_in) disable iff (sys_rst_in)
      activity_out inside {CFDS_RUN, CFDS_WAIT, CFDS_OFF};
  endproperty
  a_act_enc: assert property (p_act_enc) else $error("Activity code bad");

  property p_pwr_up;
    @(posedge clock_in) disable iff (sys_rst_in) pwr_on_in |=> err.pwr_up;
  endproperty
  a_pwr_up: assert property (p_pwr_up) else $error("Power up flag not set");

  property p_code_bnd;
    @(posedge clock_in) disable iff (sys_rst_in) err.boundary |-> (err_code_out == 2'h0);
  endproperty
  a_code_bnd: assert property (p_code_bnd) else $error("Boundary not first");

  property p_code_stk;
    @(posedge clock_in) disable iff (sys_rst_in)
      (!err.boundary && err.stack_ovf) |-> (err_code_out == 2'h1);
  endproperty
  a_code_stk: assert property (p_code_stk) else $error("Stack not second");
endmodule : cfds_core

// [tb/cfds_mem_model.sv]
`timescale 1ns/1ps
module cfds_mem_model (
  input wire logic clock_in,
  input wire logic req_in,
  input wire logic [15:0] addr_in,
  input wire logic slow_in,
  output logic ack_out,
  output logic nxm_out,
  output logic [15:0] rdata_out
);
  logic [15:0] store [0:127];
  logic [15:0] last;
  logic held;
  wire present = addr_in[15:8] == 8'h00;
  assign nxm_out = req_in && !present;
  assign ack_out = req_in && present && (!slow_in || held);
  assign rdata_out = ack_out ? store[addr_in[7:1]] : ~last;
  always @(posedge clock_in) begin
    held <= req_in && !held;
    if (ack_out) begin
      last <= rdata_out;
    end
  end
  initial begin
    last = 16'h0000;
    held = 1'b0;
    for (int k = 0; k < 128; k++) begin
      store[k] = 16'h0000;
    end
    store[0] = 16'hb5ce;
    store[2] = 16'h5a3c;
  end
endmodule : cfds_mem_model

// [tb/cpu_fetch_decode_state_test.sv]
`timescale 1ns/1ps
module cpu_fetch_decode_state_test;
  import cfds_pkg::*;
  logic clock_in, sys_rst_in, reg_wr_in, reg_rd_in, mem_req_out, mem_byte_out, mem_ack_in;
  logic mem_nxm_in, irq_pending_in, exec_done_in, exec_illegal_in, exec_sp_access_in, slow;
  logic exec_cc_we_in, exec_reg_we_in, act_set_we_in, pwr_low_in, pwr_on_in;
  logic exec_start_out, trap_out, err_any_out;
  logic [1:0] act_set_in, err_code_out, activity_out;
  logic [2:0] reg_addr_in, exec_reg_sel_in;
  logic [3:0] exec_cc_in;
  logic [7:0] mem_bytev_out;
  logic [15:0] reg_wdata_in, reg_rdata_out, mem_addr_out, mem_rdata_in, mem_word_out;
  logic [15:0] exec_reg_data_in, trap_vec_out, sp_out;
  cfds_dec_t dec_out;
  cfds_err_t err_out;
  int failures, total_checks;
  cfds_core u_cfds_core (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .mem_req_out(mem_req_out),
    .mem_addr_out(mem_addr_out), .mem_byte_out(mem_byte_out), .mem_ack_in(mem_ack_in),
    .mem_nxm_in(mem_nxm_in), .mem_rdata_in(mem_rdata_in), .mem_word_out(mem_word_out),
    .mem_bytev_out(mem_bytev_out), .irq_pending_in(irq_pending_in),
    .exec_done_in(exec_done_in), .exec_illegal_in(exec_illegal_in),
    .exec_sp_access_in(exec_sp_access_in), .exec_cc_we_in(exec_cc_we_in),
    .exec_cc_in(exec_cc_in), .exec_reg_we_in(exec_reg_we_in),
    .exec_reg_sel_in(exec_reg_sel_in), .exec_reg_data_in(exec_reg_data_in),
    .act_set_in(act_set_in), .act_set_we_in(act_set_we_in), .pwr_low_in(pwr_low_in),
    .pwr_on_in(pwr_on_in), .dec_out(dec_out), .exec_start_out(exec_start_out),
    .trap_out(trap_out), .trap_vec_out(trap_vec_out), .err_out(err_out),
    .err_code_out(err_code_out), .err_any_out(err_any_out), .activity_out(activity_out),
    .sp_out(sp_out));
  cfds_mem_model u_cfds_mem_model (.clock_in(clock_in), .req_in(mem_req_out),
    .addr_in(mem_addr_out), .slow_in(slow), .ack_out(mem_ack_in), .nxm_out(mem_nxm_in),
    .rdata_out(mem_rdata_in));
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  task conclude;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task chk_dec(input cfds_dec_t e);
    total_checks++;
    if (dec_out !== e) begin
      failures++;
      $display("FAIL dec_out expected %h seen %h", e, dec_out);
    end
  endtask : chk_dec
  task settle(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : settle
  task automatic until_high(ref logic s);
    int n;
    #1;
    for (n = 0; n < 40 && s !== 1'b1; n++) settle(1);
    if (n == 40) begin
      failures++;
      $display("FAIL wait expected 1 seen %b", s);
      conclude();
    end
  endtask : until_high
  task wr(input logic [2:0] a, input logic [15:0] v);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_wr_in <= 1'b1;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  task rd(input logic [2:0] a, input logic [15:0] e);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    #1 chk($sformatf("reg %0d", a), e, reg_rdata_out);
  endtask : rd
  task done(input logic sp, input logic ill, input logic ccwe);
    @(posedge clock_in);
    {exec_done_in, exec_sp_access_in, exec_illegal_in, exec_cc_we_in} <= {1'b1, sp, ill, ccwe};
    @(posedge clock_in);
    {exec_done_in, exec_sp_access_in, exec_illegal_in, exec_cc_we_in} <= 4'h0;
  endtask : done
  task gpr(input logic [2:0] s, input logic [15:0] v);
    @(posedge clock_in);
    {exec_reg_we_in, exec_reg_sel_in, exec_reg_data_in} <= {1'b1, s, v};
    @(posedge clock_in);
    exec_reg_we_in <= 1'b0;
  endtask : gpr
  task act(input logic [1:0] v);
    @(posedge clock_in);
    {act_set_we_in, act_set_in} <= {1'b1, v};
    @(posedge clock_in);
    act_set_we_in <= 1'b0;
  endtask : act
  task rst;
    sys_rst_in <= 1'b1;
    repeat (12) @(posedge clock_in);
    sys_rst_in <= 1'b0;
  endtask : rst
  task t_fetch;
    logic [15:0] i;
    cfds_dec_t e;
    i = 16'hb5ce;
    e = '{i[15:12], i[11:6], i[11:9], i[9], i[8:6], i[5:0], i[5:3], i[3], i[2:0],
      i[15:6], i[15:8], {{8{i[7]}}, i[7:0]}, i[15:9], i[8:6], i[15:8], i[7:6]};
    rd(CFDS_ADDR_PSW, 16'h0000);
    rd(3'h7, 16'h0000);
    until_high(exec_start_out);
    rd(CFDS_ADDR_PC, 16'h0002);
    rd(CFDS_ADDR_INSN, i);
    chk_dec(e);
  endtask : t_fetch
  task t_trace;
    wr(CFDS_ADDR_PSW, 16'hffff);
    rd(CFDS_ADDR_PSW, 16'h00ff);
    done(1'b0, 1'b0, 1'b0);
    until_high(trap_out);
    chk("trap_vec_out", 16'h000c, trap_vec_out);
    until_high(mem_req_out);
    chk("mem_addr_out", 16'h000c, mem_addr_out);
    rd(CFDS_ADDR_PSW, 16'h00ef);
  endtask : t_trace
  task t_cc;
    until_high(exec_start_out);
    exec_cc_in <= 4'ha;
    done(1'b0, 1'b0, 1'b1);
    rd(CFDS_ADDR_CC, 16'h000a);
    rd(CFDS_ADDR_PSW, 16'h00ea);
  endtask : t_cc
  task t_err;
    until_high(exec_start_out);
    gpr(CFDS_SP_IDX, 16'h00fe);
    settle(1);
    chk("sp_out", 16'h00fe, sp_out);
    done(1'b1, 1'b1, 1'b0);
    rd(CFDS_ADDR_ERR, 16'h0014);
    chk("err_code_out", 16'h0001, {14'h0, err_code_out});
    wr(CFDS_ADDR_ERR, 16'h0010);
    settle(1);
    chk("err_code_out", 16'h0003, {14'h0, err_code_out});
    wr(CFDS_ADDR_ERR, 16'h0004);
    settle(1);
    chk("err_any_out", 16'h0000, {15'h0, err_any_out});
  endtask : t_err
  task t_pwr;
    @(posedge clock_in);
    {pwr_low_in, pwr_on_in} <= 2'h3;
    @(posedge clock_in);
    {pwr_low_in, pwr_on_in} <= 2'h0;
    rd(CFDS_ADDR_ERR, 16'h0003);
    chk("err_out", 16'h0003, {10'h0, err_out});
    wr(CFDS_ADDR_ERR, 16'h0003);
    rd(CFDS_ADDR_ERR, 16'h0000);
  endtask : t_pwr
  task t_act;
    wr(CFDS_ADDR_ACT, 16'h0002);
    rd(CFDS_ADDR_ACT, 16'h0000);
    for (int v = 1; v < 4; v++) begin
      act(v[1:0]);
      rd(CFDS_ADDR_ACT, (v == 3) ? 16'h0002 : 16'(v));
    end
    chk("activity_out", 16'h0002, {14'h0, activity_out});
    done(1'b0, 1'b0, 1'b0);
    settle(3);
    chk("mem_req_out", 16'h0000, {15'h0, mem_req_out});
    irq_pending_in <= 1'b1;
    act(2'h0);
    settle(2);
    chk("mem_req_out", 16'h0000, {15'h0, mem_req_out});
    irq_pending_in <= 1'b0;
    until_high(mem_req_out);
  endtask : t_act
  task t_odd;
    until_high(exec_start_out);
    gpr(CFDS_PC_IDX, 16'h0005);
    done(1'b0, 1'b0, 1'b0);
    settle(3);
    chk("mem_bytev_out", 16'h005a, {8'h0, mem_bytev_out});
    chk("mem_word_out", 16'h5a3c, mem_word_out);
    chk("mem_byte_out", 16'h0000, {15'h0, mem_byte_out});
    rd(CFDS_ADDR_ERR, 16'h0020);
    chk("err_code_out", 16'h0000, {14'h0, err_code_out});
  endtask : t_odd
  task t_nxm;
    rst();
    rd(CFDS_ADDR_ERR, 16'h0000);
    slow <= 1'b1;
    until_high(exec_start_out);
    gpr(CFDS_PC_IDX, 16'h0400);
    done(1'b0, 1'b0, 1'b0);
    settle(4);
    chk("exec_start_out", 16'h0000, {15'h0, exec_start_out});
    rd(CFDS_ADDR_ERR, 16'h0008);
  endtask : t_nxm
  initial begin
    {sys_rst_in, reg_wr_in, reg_rd_in, irq_pending_in, exec_done_in, slow} = 6'h20;
    {exec_illegal_in, exec_sp_access_in, exec_cc_we_in, exec_reg_we_in} = 4'h0;
    {act_set_we_in, pwr_low_in, pwr_on_in, act_set_in, exec_cc_in} = 9'h0;
    {reg_addr_in, exec_reg_sel_in, reg_wdata_in, exec_reg_data_in} = 38'h0;
    failures = 0;
    total_checks = 0;
    rst();
    t_fetch();
    t_trace();
    t_cc();
    t_err();
    t_pwr();
    t_act();
    t_odd();
    t_nxm();
    conclude();
  end
endmodule : cpu_fetch_decode_state_test
